/* chain_model.sv */
`timescale 1ns/1ns
module chain_model #(
  parameter SAVE_W = 40
) (
  // Clock and reset
  input  wire              clk_sys,
  input  wire              rst_b,
  // Control
  input  wire              chain_run,
  input  wire [7:0]        ev_mask,
  // Events
  output wire [5:0]        rollover_tick,
  output wire              alarm_match,
  output wire              year_end,
  output reg  [SAVE_W-1:0] clock_time
);
  // Masked events fire once per 16 counts; a stopped chain makes none
  wire roll = chain_run && clock_time[3:0] == 4'hF;
  assign rollover_tick = ev_mask[5:0] & {6{roll}};
  assign alarm_match = ev_mask[6] & roll;
  assign year_end = ev_mask[7] & roll;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b)
      clock_time <= {SAVE_W{1'b0}};
    else if (chain_run)
      clock_time <= clock_time + 1'b1;
  end
endmodule

/* rtc_ctrl_regs.v */
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "rtc_defs.vh"

module rtc_ctrl_regs #(
  parameter SAVE_W = 40
) (
  // Clock and reset
  input  wire              clk_sys,
  input  wire              rst_b,
  // AXI4-Lite write address
  input  wire [4:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // AXI4-Lite read
  input  wire [4:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Asynchronous pins and analog status
  input  wire              power_fail_input_b,
  input  wire              standby,
  input  wire              osc_running,
  input  wire              osc_fail,
  input  wire              crystal_clk,
  // Events from the counter chain, same clock
  input  wire [5:0]        rollover_tick,
  input  wire              alarm_match,
  input  wire              year_end,
  input  wire [SAVE_W-1:0] clock_time,
  // Interrupt pins; request pin open drain, multi output open drain only in standby
  output reg               interrupt_request_pin_b,
  output reg               interrupt_request_pin_oe,
  output reg               multi_function_output,
  output reg               multi_function_output_oe,
  // Control to the counter chain
  output reg               chain_run,
  output reg               hour12_mode,
  output reg  [1:0]        leap_count,
  output reg               feb29_enable,
  output reg               single_supply,
  output reg               osc_ref_enable,
  output reg               test_mode_enable,
  output reg  [SAVE_W-1:0] saved_time
);

  // Word index decode, shared by read and write paths
  function [3:0] decode;
    input [4:0] addr;
    begin
      if (addr[1:0] != 2'b00 || addr[4:2] > `IDX_LAST) begin
        decode = 4'h8;
      end else begin
        decode = {1'b0, addr[4:2]};
      end
    end
  endfunction

  // Two-flop synchronisers for every asynchronous input
  reg [4:0] sync1_r;
  reg [4:0] sync2_r;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= 5'h01;
      sync2_r <= 5'h01;
    end else begin
      sync1_r <= {crystal_clk, osc_fail, osc_running, standby, power_fail_input_b};
      sync2_r <= sync1_r;
    end
  end
  wire pwr_pin_hi   = sync2_r[0];
  wire stby         = sync2_r[1];
  wire osc_ok       = sync2_r[2];
  wire osc_bad      = sync2_r[3];
  wire xtal         = sync2_r[4];

  reg  stby_d_r;
  reg  osc_bad_d_r;
  wire stby_enter = stby & ~stby_d_r;
  wire osc_fail_ev = osc_bad & ~osc_bad_d_r;

  // Register storage
  reg [7:0] main_r;
  reg [5:0] flags_r;
  reg       osc_fail_r;
  reg       single_r;
  reg       test_r;
  reg [7:0] tcap_r;
  reg [7:0] mode_r;
  reg [7:0] outsel_r;
  reg [7:0] pen_r;
  reg [7:0] aen_r;
  reg       osc_started_r;
  reg [SAVE_W-1:0] save_r;

  // Write channel holding
  reg [4:0] waddr_r;
  reg       aw_have_r;
  reg [7:0] wdata_r;
  reg       wbyte_r;
  reg       w_have_r;
  wire      wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire [3:0] widx = decode(waddr_r);
  wire      wr_ok = wr_go & ~widx[3];
  wire      wr_en = wr_ok & wbyte_r;
  wire      blk = main_r[`MS_BLOCK_SEL];

  wire wr_main   = wr_en & (widx[2:0] == `IDX_MAIN_STATUS);
  wire wr_flags  = wr_en & ~blk & (widx[2:0] == `IDX_SLOT3);
  wire wr_tcap   = wr_en & ~blk & (widx[2:0] == `IDX_SLOT4);
  wire wr_mode   = wr_en &  blk & (widx[2:0] == `IDX_SLOT1);
  wire wr_outsel = wr_en &  blk & (widx[2:0] == `IDX_SLOT2);
  wire wr_pen    = wr_en &  blk & (widx[2:0] == `IDX_SLOT3);
  wire wr_aen    = wr_en &  blk & (widx[2:0] == `IDX_SLOT4);

  // Read decode
  wire [3:0] ridx = decode(s_axi_araddr);
  wire      rd_go = s_axi_arvalid & ~s_axi_rvalid;
  wire      rd_flags = rd_go & ~ridx[3] & ~blk & (ridx[2:0] == `IDX_SLOT3);

  // Interrupt causes and pin levels
  wire irq_live     = ~stby | mode_r[`MODE_STANDBY_IRQ];
  wire periodic_ev  = |(rollover_tick & pen_r[5:0]);
  wire pf_irq       = main_r[`MS_PWR_FAIL] & aen_r[`IC1_PWR_EN] & irq_live;
  wire out_is_irq   = ~outsel_r[`OUT_CRYSTAL];
  wire irq_pin_nxt  = irq_live & (main_r[`MS_PERIODIC] |
                      (main_r[`MS_ALARM] & aen_r[`IC1_ALARM_EN]));
  wire pending_nxt  = irq_pin_nxt | (out_is_irq & pf_irq);

  // Bus handshakes
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      waddr_r       <= 5'h00;
      wdata_r       <= 8'h00;
      wbyte_r       <= 1'b0;
    end else begin
      // Ready is a one-cycle pulse only when a slot is free
      s_axi_awready <= s_axi_awvalid & ~aw_have_r & ~s_axi_awready;
      s_axi_wready  <= s_axi_wvalid & ~w_have_r & ~s_axi_wready;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_r <= 1'b1;
        waddr_r   <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata[7:0];
        wbyte_r  <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= widx[3] ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= ridx[3] ? `RESP_SLVERR : `RESP_OKAY;
        s_axi_rdata  <= 32'h00000000;
        if (ridx[3]) begin
          s_axi_rdata <= 32'h00000000;
        end else if (ridx[2:0] == `IDX_MAIN_STATUS) begin
          s_axi_rdata[7:0] <= main_r;
        end else if (~blk && ridx[2:0] == `IDX_SLOT3) begin
          s_axi_rdata[7:0] <= {test_r, osc_fail_r, flags_r};
        end else if (~blk && ridx[2:0] == `IDX_SLOT4) begin
          s_axi_rdata[7:0] <= {tcap_r[7], 1'b0, tcap_r[5:0]};
        end else if (blk && ridx[2:0] == `IDX_SLOT1) begin
          s_axi_rdata[7:0] <= mode_r;
        end else if (blk && ridx[2:0] == `IDX_SLOT2) begin
          s_axi_rdata[7:0] <= outsel_r;
        end else if (blk && ridx[2:0] == `IDX_SLOT3) begin
          s_axi_rdata[7:0] <= pen_r;
        end else if (blk && ridx[2:0] == `IDX_SLOT4) begin
          s_axi_rdata[7:0] <= aen_r;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Main status: causes, pending, block select, storage
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      main_r <= `RST_MAIN_STATUS;
    end else begin
      if (wr_main) begin
        main_r[7:4] <= wdata_r[7:4];
      end
      main_r[`MS_PWR_FAIL] <= ~pwr_pin_hi;
      // Set wins over the write-one clear
      if (periodic_ev) begin
        main_r[`MS_PERIODIC] <= 1'b1;
      end else if (wr_main & wdata_r[`MS_PERIODIC]) begin
        main_r[`MS_PERIODIC] <= 1'b0;
      end
      if (alarm_match) begin
        main_r[`MS_ALARM] <= 1'b1;
      end else if (wr_main & wdata_r[`MS_ALARM]) begin
        main_r[`MS_ALARM] <= 1'b0;
      end
      main_r[`MS_PENDING] <= pending_nxt;
    end
  end

  // Periodic flags, oscillator fail, supply and test bits
  localparam [7:0] FLAGS_RST = `RST_PERIODIC_FLAGS;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flags_r    <= FLAGS_RST[5:0];
      osc_fail_r <= FLAGS_RST[`PF_OSC_FAIL];
      single_r   <= 1'b1;
      test_r     <= FLAGS_RST[`PF_TEST_MODE];
    end else begin
      // A tick in the read cycle survives the read clear
      flags_r <= rollover_tick | (flags_r & {6{~rd_flags}});
      if (osc_fail_ev) begin
        osc_fail_r <= 1'b1;
      end else if (wr_mode & wdata_r[`MODE_RUN] & osc_ok) begin
        osc_fail_r <= 1'b0;
      end
      if (osc_fail_ev) begin
        single_r <= 1'b1;
      end else if (wr_flags) begin
        single_r <= wdata_r[`PF_OSC_FAIL];
        test_r   <= wdata_r[`PF_TEST_MODE];
      end
    end
  end

  // Time capture control and the saved time
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tcap_r <= `RST_TIME_CAPTURE;
      save_r <= {SAVE_W{1'b0}};
    end else begin
      if (wr_tcap) begin
        tcap_r <= wdata_r;
      end
      // Hardware clear on battery switchover wins over a write
      if (stby_enter) begin
        tcap_r[`TS_ENABLE] <= 1'b0;
      end
      if (tcap_r[`TS_ENABLE]) begin
        save_r <= clock_time;
      end
    end
  end

  // Clock mode, output select, interrupt enables
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_r        <= `RST_CLOCK_MODE;
      outsel_r      <= `RST_MULTI_OUTPUT;
      pen_r         <= `RST_PERIODIC_EN;
      aen_r         <= `RST_ALARM_EN;
      osc_started_r <= 1'b0;
    end else begin
      if (osc_ok) begin
        osc_started_r <= 1'b1;
      end
      if (wr_mode) begin
        mode_r <= wdata_r;
      end else if (year_end) begin
        mode_r[`MODE_LEAP_HI:`MODE_LEAP_LO] <=
          mode_r[`MODE_LEAP_HI:`MODE_LEAP_LO] + 2'b01;
      end
      // Run held low until the oscillator has started, dropped on a fail
      if (osc_fail_ev || !osc_started_r) begin
        mode_r[`MODE_RUN] <= 1'b0;
      end
      if (wr_outsel) begin
        outsel_r <= wdata_r;
      end
      if (wr_pen) begin
        pen_r <= wdata_r;
      end
      if (wr_aen) begin
        aen_r <= wdata_r;
      end
      if (stby_enter && !mode_r[`MODE_STANDBY_IRQ]) begin
        pen_r[5:0] <= 6'h00;
        aen_r[`IC1_ALARM_EN] <= 1'b0;
        aen_r[`IC1_PWR_EN] <= 1'b0;
      end
    end
  end

  // Registered outputs
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stby_d_r                 <= 1'b0;
      osc_bad_d_r              <= 1'b0;
      interrupt_request_pin_b  <= 1'b1;
      interrupt_request_pin_oe <= 1'b0;
      multi_function_output    <= 1'b1;
      multi_function_output_oe <= 1'b0;
      chain_run                <= 1'b0;
      hour12_mode              <= 1'b0;
      leap_count               <= 2'b00;
      feb29_enable             <= 1'b1;
      single_supply            <= 1'b1;
      osc_ref_enable           <= 1'b0;
      test_mode_enable         <= 1'b0;
      saved_time               <= {SAVE_W{1'b0}};
    end else begin
      stby_d_r    <= stby;
      osc_bad_d_r <= osc_bad;
      // Request pin open drain: only ever pulls low; multi output drives both levels outside standby
      interrupt_request_pin_b  <= 1'b0;
      interrupt_request_pin_oe <= irq_pin_nxt;
      if (out_is_irq) begin
        multi_function_output    <= ~pf_irq;
        multi_function_output_oe <= stby ? pf_irq : 1'b1;
      end else begin
        multi_function_output    <= xtal;
        multi_function_output_oe <= stby ? ~xtal : 1'b1;
      end
      chain_run        <= mode_r[`MODE_RUN] & osc_started_r & ~osc_fail_ev;
      hour12_mode      <= mode_r[`MODE_HOUR12];
      leap_count       <= mode_r[`MODE_LEAP_HI:`MODE_LEAP_LO];
      feb29_enable     <= (mode_r[`MODE_LEAP_HI:`MODE_LEAP_LO] == 2'b00);
      single_supply    <= single_r;
      osc_ref_enable   <= ~single_r;
      test_mode_enable <= test_r;
      saved_time       <= save_r;
    end
  end

endmodule

/* rtc_ctrl_regs_sva.sv */
`timescale 1ns/1ns
module rtc_ctrl_regs_chk (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_b,
  // Watched signals
  input wire logic       s_axi_wvalid,
  input wire logic       standby,
  input wire logic       osc_fail,
  input wire logic [5:0] rollover_tick,
  input wire logic       alarm_match,
  input wire logic       year_end,
  input wire logic       interrupt_request_pin_b,
  input wire logic       interrupt_request_pin_oe,
  input wire logic       multi_function_output_oe,
  input wire logic       chain_run,
  input wire logic [1:0] leap_count,
  input wire logic       feb29_enable,
  input wire logic       single_supply,
  input wire logic       osc_ref_enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_run_stop;
    $rose(osc_fail) |-> ##[1:5] !chain_run;
  endproperty
  a_run_stop: assert property (p_run_stop) else $error("chain kept running");
  property p_fail_single;
    $rose(osc_fail) |-> ##[1:5] single_supply;
  endproperty
  a_fail_single: assert property (p_fail_single) else $error("supply not single");
  property p_ref;
    single_supply != osc_ref_enable;
  endproperty
  a_ref: assert property (p_ref) else $error("reference mismatch");
  property p_mfo_drive;
    (!standby)[*5] |-> multi_function_output_oe;
  endproperty
  a_mfo_drive: assert property (p_mfo_drive) else $error("output undriven");
  property p_pin_low;
    interrupt_request_pin_oe |-> !interrupt_request_pin_b;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("request pin high");
  property p_irq_cause;
    $rose(interrupt_request_pin_oe) |-> $past(|rollover_tick || alarm_match, 2)
      || $past(|rollover_tick || alarm_match, 3) || $past(standby, 3) || $past(standby, 4);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("request without cause");
  property p_leap_step;
    year_end && !s_axi_wvalid && !$past(s_axi_wvalid) |->
      ##2 leap_count == $past(leap_count, 2) + 2'h1;
  endproperty
  a_leap_step: assert property (p_leap_step) else $error("leap count stuck");
  property p_feb29;
    $stable(leap_count) |-> feb29_enable == (leap_count == 2'h0);
  endproperty
  a_feb29: assert property (p_feb29) else $error("day 29 enable wrong");
  c_irq: cover property ($rose(interrupt_request_pin_oe));
  c_year: cover property (year_end);
  c_fail: cover property ($rose(osc_fail));
endmodule

bind rtc_ctrl_regs rtc_ctrl_regs_chk u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .s_axi_wvalid(s_axi_wvalid), .standby(standby),
  .osc_fail(osc_fail), .rollover_tick(rollover_tick), .alarm_match(alarm_match),
  .year_end(year_end), .interrupt_request_pin_b(interrupt_request_pin_b),
  .interrupt_request_pin_oe(interrupt_request_pin_oe), .chain_run(chain_run),
  .multi_function_output_oe(multi_function_output_oe), .leap_count(leap_count),
  .feb29_enable(feb29_enable), .single_supply(single_supply), .osc_ref_enable(osc_ref_enable)
);

/* rtc_defs.vh */
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH

// Register indexes; byte address is four times the index
`define IDX_MAIN_STATUS       3'h0
`define IDX_SLOT1             3'h1
`define IDX_SLOT2             3'h2
`define IDX_SLOT3             3'h3
`define IDX_SLOT4             3'h4
`define IDX_LAST              3'h4

// Main status fields
`define MS_PENDING            0
`define MS_PWR_FAIL           1
`define MS_PERIODIC           2
`define MS_ALARM              3
`define MS_BLOCK_SEL          6

// Periodic flag fields
`define PF_OSC_FAIL           6
`define PF_TEST_MODE          7

// Time capture control fields
`define TS_ENABLE             7
`define TS_HOLE               6

// Clock mode control fields
`define MODE_LEAP_LO          0
`define MODE_LEAP_HI          1
`define MODE_HOUR12           2
`define MODE_RUN              3
`define MODE_STANDBY_IRQ      4

// Multi output select field
`define OUT_CRYSTAL           7

// Interrupt control 1 fields
`define IC1_ALARM_EN          6
`define IC1_PWR_EN            7

// Reset values
`define RST_MAIN_STATUS       8'h00
`define RST_PERIODIC_FLAGS    8'h40
`define RST_TIME_CAPTURE      8'h00
`define RST_CLOCK_MODE        8'h00
`define RST_MULTI_OUTPUT      8'h00
`define RST_PERIODIC_EN       8'h00
`define RST_ALARM_EN          8'h00

// Bus answers
`define RESP_OKAY             2'b00
`define RESP_SLVERR           2'b10

`endif

/* tb_rtc_ctrl_regs.sv */
`timescale 1ns/1ns
`include "rtc_defs.vh"
module tb_rtc_ctrl_regs;
  logic        clk_sys;
  logic        rst_b = 0, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
  logic [4:0]  aw_a = 0, ar_a = 0;
  logic [31:0] w_d = 0, r_data, rd_val, snap;
  logic        aw_r, w_r, b_v, ar_r, r_v, alarm, yend, xtal = 0;
  logic [1:0]  b_resp, r_resp, resp, leap;
  logic        pf_b = 1, stby = 0, osc_ok = 0, osc_f = 0;
  logic [5:0]  tick;
  logic [7:0]  mask = 0;
  logic [39:0] ctime, stime;
  logic        irq_b, irq_oe, outp, outp_oe, run, h12, feb29, ssup, oref, tmode;
  int          err_count = 0, compares = 0;

  initial begin
    clk_sys = 0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) xtal <= ctime[4];

  rtc_ctrl_regs DUT (
    .clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
    .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
    .s_axi_wready(w_r), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
    .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_data),
    .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r), .power_fail_input_b(pf_b),
    .standby(stby), .osc_running(osc_ok), .osc_fail(osc_f), .crystal_clk(xtal),
    .rollover_tick(tick), .alarm_match(alarm), .year_end(yend), .clock_time(ctime),
    .interrupt_request_pin_b(irq_b), .interrupt_request_pin_oe(irq_oe),
    .multi_function_output(outp), .multi_function_output_oe(outp_oe), .chain_run(run),
    .hour12_mode(h12), .leap_count(leap), .feb29_enable(feb29), .single_supply(ssup),
    .osc_ref_enable(oref), .test_mode_enable(tmode), .saved_time(stime)
  );
  chain_model u_chain (
    .clk_sys(clk_sys), .rst_b(rst_b), .chain_run(run), .ev_mask(mask),
    .rollover_tick(tick), .alarm_match(alarm), .year_end(yend), .clock_time(ctime)
  );

  task automatic chk(input [31:0] seen, input [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input [4:0] a, input [7:0] d);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge clk_sys);
    aw_a <= a;
    w_d <= {24'h0, d};
    aw_v <= 1;
    w_v <= 1;
    b_r <= 1;
    while (!(ad && wd)) begin
      @(posedge clk_sys);
      if (aw_r) aw_v <= 0;
      if (w_r) w_v <= 0;
      ad = ad | aw_r;
      wd = wd | w_r;
    end
    while (!b_v) @(posedge clk_sys);
    resp = b_resp;
    b_r <= 0;
  endtask
  task automatic rd(input [4:0] a);
    @(posedge clk_sys);
    ar_a <= a;
    ar_v <= 1;
    r_r <= 1;
    do begin
      @(posedge clk_sys);
      if (ar_r) ar_v <= 0;
    end while (!r_v);
    rd_val = r_data;
    resp = r_resp;
    r_r <= 0;
  endtask
  task automatic rc(input [4:0] a, input [31:0] e);
    rd(a);
    chk(rd_val, e);
  endtask
  // Events are gated by the running chain, so start it first
  task automatic ev(input [7:0] m);
    mask <= m;
    repeat (40) @(posedge clk_sys);
    mask <= 8'h00;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic final_report;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1;
    rc(5'h00, 32'h00);
    rc(5'h0C, 32'h40);
    rc(5'h10, 32'h00);
    $display("test reset done");
    osc_ok <= 1;
    repeat (5) @(posedge clk_sys);
    wr(5'h00, 8'h40);
    rc(5'h00, 32'h40);
    wr(5'h04, 8'h0C);
    repeat (2) @(posedge clk_sys);
    chk({h12, run}, 2'b11);
    wr(5'h08, 8'h80);
    rc(5'h08, 32'h80);
    wr(5'h00, 8'h00);
    rc(5'h0C, 32'h00);
    wr(5'h0C, 8'h80);
    repeat (2) @(posedge clk_sys);
    chk({tmode, ssup, oref}, 3'b101);
    $display("test start done");
    ev(8'h01);
    rc(5'h00, 32'h00);
    chk(irq_oe, 0);
    rc(5'h0C, 32'h81);
    rc(5'h0C, 32'h80);
    wr(5'h00, 8'h40);
    wr(5'h0C, 8'h01);
    ev(8'h01);
    rc(5'h00, 32'h45);
    chk(irq_oe, 1);
    rc(5'h00, 32'h45);
    wr(5'h00, 8'h44);
    rc(5'h00, 32'h40);
    chk(irq_oe, 0);
    $display("test periodic done");
    ev(8'h40);
    rc(5'h00, 32'h48);
    wr(5'h00, 8'h48);
    wr(5'h10, 8'h40);
    ev(8'h40);
    rc(5'h00, 32'h49);
    wr(5'h00, 8'h48);
    rc(5'h00, 32'h40);
    pf_b <= 0;
    repeat (6) @(posedge clk_sys);
    rc(5'h00, 32'h42);
    wr(5'h00, 8'h42);
    rc(5'h00, 32'h42);
    // Output back to interrupt mode, alarm and power fail enabled
    wr(5'h08, 8'h00);
    wr(5'h10, 8'hC0);
    rc(5'h00, 32'h43);
    chk(outp, 0);
    pf_b <= 1;
    repeat (6) @(posedge clk_sys);
    chk(outp, 1);
    rc(5'h00, 32'h40);
    ev(8'h80);
    $display("test alarm done");
    wr(5'h00, 8'h00);
    wr(5'h10, 8'h80);
    snap = stime[31:0];
    rc(5'h10, 32'h80);
    chk(stime[31:0] != snap, 1);
    wr(5'h00, 8'h40);
    wr(5'h0C, 8'h3F);
    stby <= 1;
    repeat (6) @(posedge clk_sys);
    snap = stime[31:0];
    repeat (10) @(posedge clk_sys);
    chk(stime[31:0], snap);
    stby <= 0;
    repeat (6) @(posedge clk_sys);
    rc(5'h0C, 32'h00);
    rc(5'h10, 32'h00);
    wr(5'h00, 8'h00);
    rc(5'h10, 32'h00);
    rd(5'h14);
    chk(resp, `RESP_SLVERR);
    chk(rd_val, 32'h0);
    $display("test standby done");
    osc_f <= 1;
    repeat (6) @(posedge clk_sys);
    chk({run, ssup}, 2'b01);
    // Test bit still written, minute flag left from the second periodic run
    rc(5'h0C, 32'hC1);
    $display("test oscillator fail done");
    final_report;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    final_report;
  end
endmodule
